// ==== include/id_map_regs.vh ====
/*
 * register offsets, field positions, reset values and sizes of the
 * identity mapping table, its per-port access pair and per-partition guard.
 * assumes inclusion by bare name from design files.
 */
`ifndef ID_MAP_REGS_VH
`define ID_MAP_REGS_VH

// ----------------------------------------------------------------
// table geometry
// ----------------------------------------------------------------
`define MAP_ENTRIES 64
`define MAP_IDX_W 6
`define NUM_PART 8
`define PART_W 3

// ----------------------------------------------------------------
// entry field positions
// ----------------------------------------------------------------
`define ENT_IN_USE 0
`define ENT_SUBUNIT_LO 1
`define ENT_SUBUNIT_HI 3
`define ENT_SLOT_LO 4
`define ENT_SLOT_HI 8
`define ENT_BUS_LO 9
`define ENT_BUS_HI 16
`define ENT_OWNER_LO 17
`define ENT_OWNER_HI 19
`define ENT_ADDR_TYPE 29
`define ENT_CPL_SNOOP 30
`define ENT_REQ_SNOOP 31
`define ENT_WRITE_MASK 32'hE00F_FFFF

// ----------------------------------------------------------------
// register offsets (per-port space and switch space)
// ----------------------------------------------------------------
`define OFS_TABLE_POINTER 12'h000
`define OFS_TABLE_DATA 12'h004
`define OFS_TABLE_STATUS 12'h008
`define OFS_GUARD_BASE 12'h100

// ----------------------------------------------------------------
// guard and status register fields and reset values
// ----------------------------------------------------------------
`define GRD_START_LO 0
`define GRD_START_HI 5
`define GRD_LAST_LO 8
`define GRD_LAST_HI 13
`define GRD_MASK_LO 16
`define GRD_MASK_HI 23
`define GRD_RESET 32'h0000_3F00
`define STS_FAULT 0

`endif

// ==== core/id_map_store.v ====
/*
 * 64 x 32 storage of mapping entries, one access port, registered read data,
 * plus a per-entry in-use vector cleared by reset.
 * assumes one access per cycle from the owning table guard.
 */
module id_map_store (
   // clock and reset
   input wire clk_sys,
   input wire rst_sync_n,
   // access port
   input wire wr_en,
   input wire [5:0] addr,
   input wire [31:0] wr_data,
   output reg [31:0] rd_data_reg,
   // in-use flags for lookup
   output wire [63:0] in_use_vec,
   // direct read for lookup
   input wire [5:0] look_addr,
   output wire [31:0] look_data
);

   reg [31:0] mem [0:63];
   reg [63:0] in_use_reg;

   assign in_use_vec = in_use_reg;
   assign look_data = {mem[look_addr][31:1], in_use_reg[look_addr]};

   // fields other than in-use are not reset; contents survive soft resets
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
   end

   // in-use bits cleared by the fundamental reset and by writes with bit 0 low
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         in_use_reg <= 64'h0000_0000_0000_0000;
      end else if (wr_en) begin
         in_use_reg[addr] <= wr_data[0];
      end
   end

   // registered read data
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_data_reg <= 32'h0000_0000;
      end else begin
         rd_data_reg <= {mem[addr][31:1], in_use_reg[addr]};
      end
   end

endmodule

// ==== core/id_map_table_guard.v ====
/*
 * shared identity mapping table with per-partition window and owner
 * write blocking, reached through pointer/data pairs per port.
 * assumes the management front end decodes requests to this block
 * from direct config, memory, eeprom, smbus or indirect paths, one dword
 * access per strobe, and that rst_n is the fundamental reset.
 */
`include "id_map_regs.vh"

module id_map_table_guard (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // register access request
   input wire req_valid,
   input wire req_write,
   input wire req_indirect,
   input wire [11:0] req_offset,
   input wire [2:0] req_port,
   input wire [31:0] req_wdata,
   // register access answer
   output reg rsp_valid_reg,
   output reg [31:0] rsp_rdata_reg,
   // lookup request
   input wire [15:0] look_req_id,
   input wire [2:0] look_part,
   // lookup answer
   output reg look_hit_reg,
   output reg [5:0] look_entry_reg,
   output reg [2:0] look_flags_reg
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_sync_n;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_sync_n = rst_sync_reg;

   // ----------------------------------------------------------------
   // per-port pointers and per-partition guards
   // ----------------------------------------------------------------
   reg [5:0] pointer_reg [0:`NUM_PART-1];
   reg [31:0] guard_reg [0:`NUM_PART-1];
   reg fault_reg [0:`NUM_PART-1];

   // address decode; indirect paths never reach the pair
   wire hit_ptr;
   wire hit_data;
   wire hit_sts;
   wire hit_guard;
   wire [2:0] guard_sel;
   wire [11:0] guard_base;
   // guard block base kept at full offset width; only its upper bits compare
   assign guard_base = `OFS_GUARD_BASE;
   // the indirect paths are refused here so no pointer or entry can be
   // reached through them, whatever offset they carry
   assign hit_ptr = req_valid && !req_indirect &&
      req_offset == `OFS_TABLE_POINTER;
   assign hit_data = req_valid && !req_indirect &&
      req_offset == `OFS_TABLE_DATA;
   assign hit_sts = req_valid && req_offset == `OFS_TABLE_STATUS;
   assign hit_guard = req_valid &&
      req_offset[11:5] == guard_base[11:5];
   assign guard_sel = req_offset[4:2];

   // window translation of the requesting port's partition
   wire [31:0] cur_guard;
   wire [6:0] phys_sum;
   wire [5:0] win_last;
   wire win_bad;
   wire owner_bad;
   wire [2:0] wr_owner;
   wire [7:0] blk_mask;
   assign cur_guard = guard_reg[req_port];
   assign win_last = cur_guard[`GRD_LAST_HI:`GRD_LAST_LO];
   assign phys_sum = {1'b0, pointer_reg[req_port]} +
      {1'b0, cur_guard[`GRD_START_HI:`GRD_START_LO]};
   assign win_bad = phys_sum > {1'b0, win_last};
   assign wr_owner = req_wdata[`ENT_OWNER_HI:`ENT_OWNER_LO];
   assign blk_mask = cur_guard[`GRD_MASK_HI:`GRD_MASK_LO];
   assign owner_bad = req_write && blk_mask[wr_owner];

   wire violation;
   wire store_wr;
   assign violation = hit_data && (win_bad || owner_bad);
   assign store_wr = hit_data && req_write && !violation;

   // ----------------------------------------------------------------
   // table storage
   // ----------------------------------------------------------------
   wire [31:0] store_rd;
   wire [63:0] in_use_vec;
   reg [5:0] look_idx;
   wire [31:0] look_data;

   id_map_store u_store (
      .clk_sys(clk_sys),
      .rst_sync_n(rst_sync_n),
      .wr_en(store_wr),
      .addr(phys_sum[5:0]),
      .wr_data(req_wdata & `ENT_WRITE_MASK),
      .rd_data_reg(store_rd),
      .in_use_vec(in_use_vec),
      .look_addr(look_idx),
      .look_data(look_data)
   );

   // ----------------------------------------------------------------
   // register writes and sticky fault flags
   // ----------------------------------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < `NUM_PART; gp = gp + 1) begin : g_part
         // guards reset to flat access: start 0, last 63, no blocking
         always @(posedge clk_sys or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               pointer_reg[gp] <= 6'h00;
               guard_reg[gp] <= `GRD_RESET;
               fault_reg[gp] <= 1'b0;
            end else begin
               if (hit_ptr && req_write && req_port == gp) begin
                  pointer_reg[gp] <= req_wdata[5:0];
               end
               if (hit_guard && req_write && guard_sel == gp) begin
                  guard_reg[gp] <= req_wdata & 32'h00FF_3F3F;
               end
               // set beats clear; success never clears
               if (violation && req_port == gp) begin
                  fault_reg[gp] <= 1'b1;
               end else if (hit_sts && req_write && req_port == gp &&
                  req_wdata[`STS_FAULT]) begin
                  fault_reg[gp] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // read answer, two cycles after the request
   // ----------------------------------------------------------------
   reg rd_pending_reg;
   reg rd_from_store_reg;
   reg [31:0] rd_hold_reg;

   // data reads come from the registered store output next cycle
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_pending_reg <= 1'b0;
         rd_from_store_reg <= 1'b0;
         rd_hold_reg <= 32'h0000_0000;
      end else begin
         rd_pending_reg <= req_valid;
         rd_from_store_reg <= hit_data && !req_write && !violation;
         if (hit_ptr) begin
            rd_hold_reg <= {26'h000_0000, pointer_reg[req_port]};
         end else if (hit_sts) begin
            rd_hold_reg <= {31'h0000_0000, fault_reg[req_port]};
         end else if (hit_guard) begin
            rd_hold_reg <= guard_reg[guard_sel];
         end else begin
            rd_hold_reg <= 32'h0000_0000; // violations and unmapped
         end
      end
   end

   // answer mux registered so data output leaves a flip-flop;
   // read data is loaded only with an answer and stands until the next,
   // so a slow reader may pick it up any time before the next request
   // (writes also reload it: pointer, status and guard writes with the value before the write, data writes with zero)
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rsp_valid_reg <= 1'b0;
         rsp_rdata_reg <= 32'h0000_0000;
      end else begin
         rsp_valid_reg <= rd_pending_reg;
         if (rd_pending_reg) begin
            if (rd_from_store_reg) begin
               rsp_rdata_reg <= store_rd;
            end else begin
               rsp_rdata_reg <= rd_hold_reg;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // requester lookup
   // ----------------------------------------------------------------
   reg [63:0] match_vec;
   integer i;
   // compare id and owner partition in every in-use entry
   always @* begin
      match_vec = 64'h0000_0000_0000_0000;
      look_idx = 6'h00;
      for (i = 0; i < `MAP_ENTRIES; i = i + 1) begin
         match_vec[i] = in_use_vec[i] &&
            u_store.mem[i][`ENT_BUS_HI:`ENT_SUBUNIT_LO] == look_req_id &&
            u_store.mem[i][`ENT_OWNER_HI:`ENT_OWNER_LO] == look_part;
      end
      // lowest match wins; several matches mean bad setup anyway
      for (i = `MAP_ENTRIES - 1; i >= 0; i = i - 1) begin
         if (match_vec[i]) begin
            look_idx = i[5:0];
         end
      end
   end

   // registered lookup answer
   always @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         look_hit_reg <= 1'b0;
         look_entry_reg <= 6'h00;
         look_flags_reg <= 3'h0;
      end else begin
         look_hit_reg <= |match_vec;
         look_entry_reg <= look_idx;
         look_flags_reg <= look_data[`ENT_REQ_SNOOP:`ENT_ADDR_TYPE];
      end
   end

endmodule

// ==== bench/id_map_asserts.sv ====
/* port checker for the mapping table guard.
   assumes only the top's ports; bound from the bench top file. */
`include "id_map_regs.vh"
module id_map_asserts (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // request side
   input wire req_valid,
   input wire req_write,
   input wire req_indirect,
   input wire [11:0] req_offset,
   input wire [15:0] look_req_id,
   input wire [2:0] look_part,
   // answer side
   input wire rsp_valid_reg,
   input wire [31:0] rsp_rdata_reg,
   input wire look_hit_reg,
   input wire [5:0] look_entry_reg
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // a plain read of one register offset
   sequence rd_s(off);
      req_valid && !req_write && req_offset == off;
   endsequence
   // quiet lookup inputs with no table traffic in flight
   sequence calm_s;
      $stable(look_req_id) && $stable(look_part) && !req_valid
         && !$past(req_valid) && !$past(req_valid, 2);
   endsequence
   answer_delay_a: assert property (req_valid |-> ##2 rsp_valid_reg)
      else $error("answer not two cycles after request");
   answer_cause_a: assert property (rsp_valid_reg |-> $past(req_valid, 2))
      else $error("answer without request");
   rdata_hold_a: assert property (!rsp_valid_reg |-> $stable(rsp_rdata_reg))
      else $error("read data moved between answers");
   indirect_zero_a: assert property (req_valid && !req_write && req_indirect
      && req_offset <= `OFS_TABLE_DATA |-> ##2 rsp_rdata_reg == 32'h0)
      else $error("pair readable through indirect path");
   rsvd_zero_a: assert property (rd_s(`OFS_TABLE_DATA) ##2 rsp_valid_reg
      |-> rsp_rdata_reg[28:20] == 9'h0)
      else $error("reserved entry bits not zero");
   status_bits_a: assert property (rd_s(`OFS_TABLE_STATUS) |-> ##2
      rsp_rdata_reg[31:1] == 31'h0)
      else $error("status upper bits not zero");
   look_steady_a: assert property (calm_s |=> $stable(look_hit_reg)
      && $stable(look_entry_reg))
      else $error("lookup changed with steady inputs");
   reset_clear_a: assert property (disable iff (1'b0) !rst_n |=>
      !look_hit_reg && !rsp_valid_reg)
      else $error("outputs active in reset");
endmodule

// ==== bench/id_map_table_guard_tb.sv ====
/* directed bench for the mapping table guard: register path, guard
   windows, owner blocking, indirect refusal, lookup and reset.
   assumes the design files and the register header. */
`include "id_map_regs.vh"
module id_map_table_guard_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] PT = `OFS_TABLE_POINTER;
   localparam logic [11:0] DT = `OFS_TABLE_DATA;
   localparam logic [11:0] ST = `OFS_TABLE_STATUS;
   localparam logic [11:0] GD = `OFS_GUARD_BASE + 12'h008;
   // entry 63 owner 5; a, b, c owners 0, 1, 1
   localparam logic [31:0] E63 = {3'b101, 9'h0, 3'd5, 8'hA5, 5'h13, 3'h6, 1'b1};
   localparam logic [31:0] EA = 32'h4001_2345;
   localparam logic [31:0] EB = 32'h2003_0ACF;
   localparam logic [31:0] EC = 32'h8002_7777;
   logic clk_sys, rst_n, req_valid, req_write, req_indirect;
   logic [11:0] req_offset;
   logic [2:0] req_port, look_part, look_flags_reg;
   logic [31:0] req_wdata, rsp_rdata_reg, q;
   logic [15:0] look_req_id;
   logic rsp_valid_reg, look_hit_reg;
   logic [5:0] look_entry_reg;
   int n_mismatch = 0;
   int checked = 0;
   id_map_table_guard id_map_table_guard_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .req_valid(req_valid), .req_write(req_write),
      .req_indirect(req_indirect), .req_offset(req_offset),
      .req_port(req_port), .req_wdata(req_wdata),
      .rsp_valid_reg(rsp_valid_reg), .rsp_rdata_reg(rsp_rdata_reg),
      .look_req_id(look_req_id), .look_part(look_part),
      .look_hit_reg(look_hit_reg), .look_entry_reg(look_entry_reg),
      .look_flags_reg(look_flags_reg));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle strobe, answer sampled at falling edges
   task automatic acc(input logic w, ind, input logic [2:0] p,
         input logic [11:0] off, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= w;
      req_indirect <= ind;
      req_port <= p;
      req_offset <= off;
      req_wdata <= d;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid_reg !== 1'b1 && n < 8);
      q = rsp_rdata_reg;
      chk("answer delay", 32'd2, n);
   endtask
   task automatic put(input logic [2:0] p, input logic [31:0] ptr, d);
      acc(1'b1, 1'b0, p, PT, ptr);
      acc(1'b1, 1'b0, p, DT, d);
   endtask
   task automatic get(input logic [2:0] p, input logic [31:0] ptr);
      acc(1'b1, 1'b0, p, PT, ptr);
      acc(1'b0, 1'b0, p, DT, 32'h0);
   endtask
   task automatic look(input logic [15:0] id, input logic [2:0] part);
      @(posedge clk_sys);
      look_req_id <= id;
      look_part <= part;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_flat;
      acc(1'b0, 1'b0, 3'd2, GD, 32'h0);
      chk("guard reset", `GRD_RESET, q);
      look(16'hA59E, 3'd5);
      chk("hit clear", 32'h0, look_hit_reg);
      put(3'd0, 32'd63, E63 | 32'h1FF0_0000);
      get(3'd3, 32'd63);
      chk("shared entry", E63, q);
      $display("test flat done");
   endtask
   task automatic t_look;
      look(16'hA59E, 3'd5);
      chk("hit", {22'h0, 1'b1, 3'b101, 6'd63},
         {22'h0, look_hit_reg, look_flags_reg, look_entry_reg});
      look(16'hA59E, 3'd4);
      chk("miss part", 32'h0, look_hit_reg);
      put(3'd0, 32'd63, E63 & 32'hFFFF_FFFE);
      look(16'hA59E, 3'd5);
      chk("miss unused", 32'h0, look_hit_reg);
      $display("test lookup done");
   endtask
   task automatic t_guard;
      put(3'd0, 32'd12, EA);
      put(3'd0, 32'd8, EB);
      acc(1'b1, 1'b0, 3'd2, GD, 32'h0020_0B08);
      acc(1'b0, 1'b0, 3'd2, GD, 32'h0);
      chk("guard", 32'h0020_0B08, q);
      put(3'd2, 32'd3, EC);
      get(3'd0, 32'd11);
      chk("window write", EC, q);
      get(3'd2, 32'd4);
      chk("beyond read", 32'h0, q);
      acc(1'b0, 1'b0, 3'd2, ST, 32'h0);
      chk("fault set", 32'h1, q);
      put(3'd2, 32'd4, EC);
      get(3'd0, 32'd12);
      chk("beyond write", EA, q);
      put(3'd2, 32'd0, E63);
      get(3'd0, 32'd8);
      chk("blocked owner", EB, q);
      get(3'd2, 32'd3);
      acc(1'b0, 1'b0, 3'd2, ST, 32'h0);
      chk("fault sticky", 32'h1, q);
      acc(1'b1, 1'b0, 3'd2, ST, 32'h1);
      acc(1'b0, 1'b0, 3'd2, ST, 32'h0);
      chk("fault cleared", 32'h0, q);
      acc(1'b0, 1'b0, 3'd0, ST, 32'h0);
      chk("other port", 32'h0, q);
      $display("test guard done");
   endtask
   task automatic t_indirect;
      acc(1'b1, 1'b0, 3'd0, PT, 32'd12);
      acc(1'b0, 1'b1, 3'd0, DT, 32'h0);
      chk("indirect read", 32'h0, q);
      acc(1'b1, 1'b1, 3'd0, PT, 32'd8);
      acc(1'b1, 1'b1, 3'd0, DT, EC);
      acc(1'b0, 1'b0, 3'd0, DT, 32'h0);
      chk("indirect write", EA, q);
      $display("test indirect done");
   endtask
   task automatic t_reset;
      look(16'h3BBB, 3'd1);
      chk("hit before", 32'h1, look_hit_reg);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      get(3'd2, 32'd11);
      chk("in use cleared", 32'h0, q[0]);
      acc(1'b0, 1'b0, 3'd2, ST, 32'h0);
      chk("no fault", 32'h0, q);
      look(16'h3BBB, 3'd1);
      chk("hit after", 32'h0, look_hit_reg);
      $display("test reset done");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog: far beyond the roughly 150 cycles the tests need
   initial begin
      #200_000;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_indirect = 1'b0;
      req_offset = 12'h000;
      req_port = 3'd0;
      req_wdata = 32'h0;
      look_req_id = 16'h0;
      look_part = 3'd0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_flat;
      t_look;
      t_guard;
      t_indirect;
      t_reset;
      give_verdict;
   end
endmodule
bind id_map_table_guard id_map_asserts id_map_asserts_i (.clk_sys(clk_sys),
   .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
   .req_indirect(req_indirect), .req_offset(req_offset),
   .look_req_id(look_req_id), .look_part(look_part),
   .rsp_valid_reg(rsp_valid_reg), .rsp_rdata_reg(rsp_rdata_reg),
   .look_hit_reg(look_hit_reg), .look_entry_reg(look_entry_reg));
